// ### rtl/arcs_pkg.sv
// shared constants for the converter set-up and coding block
package arcs_pkg;
  // register bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // converter result width and dac scaling
  localparam int CODE_W = 12;
  localparam int LSB_DIV = 4096;  // one lsb is the reference over this
  localparam logic [11:0] CODE_MID = 12'h800;  // msb trial / midscale
  // register indices (byte address equals index)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RESULT_A = 4'h2;
  localparam logic [3:0] REG_RESULT_B = 4'h3;
  localparam logic [3:0] REG_COUNT = 4'h4;
  // field positions
  localparam int CTRL_ACCEPT = 0;  // accept new results
  localparam int ST_RANGE = 0;  // double-reference span latched
  localparam int ST_CODING = 1;  // twos complement coding
  localparam int ST_PAIR = 2;  // second channel pair converted
  localparam int ST_NEW = 3;  // unread result pending
  localparam int ST_BUSY = 4;  // frame in progress
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0001;
  // falling serial clock edge counts within a frame
  localparam logic [4:0] EDGE_SPAN_B = 5'h07;  // count before 8th edge
  localparam logic [4:0] EDGE_SAR_FIRST = 5'h03;  // count before edge 4
  localparam logic [4:0] EDGE_SAR_LAST = 5'h0E;  // count before edge 15
  localparam logic [4:0] EDGE_DONE = 5'h0F;  // count before edge 16
  localparam logic [4:0] EDGE_END = 5'h10;  // frame fully clocked
endpackage

// ### rtl/arcs_sar_if.sv
// link-side bundle between frame control and the two sar engines
`timescale 1ns/1ns
`default_nettype none
interface arcs_sar_if;
  logic [4:0] edge_cnt;  // falling serial clock edges seen in frame
  logic [1:0] comp;  // comparator: input above trial, per converter
  logic [1:0][11:0] trial;  // dac trial code, per converter
  modport ctl (output edge_cnt, output comp, input trial);
  modport core (input edge_cnt, input comp, output trial);
endinterface
`default_nettype wire

// ### rtl/arcs_sar.sv
// dual successive-approximation engine clocked by the serial clock
`timescale 1ns/1ns
`default_nettype none
module arcs_sar (
  input wire logic sclk,
  input wire logic cs_b,
  arcs_sar_if.core sar
);
  // offset that maps the last sar edge count onto bit zero
  localparam logic [4:0] EDGE_SAR_LAST_W = arcs_pkg::EDGE_SAR_LAST;

  // one engine per converter, both run off the same edges
  for (genvar i = 0; i < 2; i++) begin : g_conv
    logic [11:0] trial;  // current trial / final code
    logic [11:0] next_trial;
    logic [3:0] bit_pos;  // bit under decision this edge

    // decide one bit per edge, msb first, then try the next one
    always_comb begin
      next_trial = trial;
      bit_pos = 4'(5'(EDGE_SAR_LAST_W) - sar.edge_cnt);
      if (sar.edge_cnt >= arcs_pkg::EDGE_SAR_FIRST &&
          sar.edge_cnt <= arcs_pkg::EDGE_SAR_LAST) begin
        if (!sar.comp[i]) begin
          next_trial[bit_pos] = 1'b0;  // overshoot, drop this bit
        end
        if (bit_pos != 4'h0) begin
          next_trial[bit_pos - 4'h1] = 1'b1;
        end
      end
    end

    // idle frame select parks the trial at midscale for the next start
    always_ff @(negedge sclk or posedge cs_b) begin
      if (cs_b) begin
        trial <= arcs_pkg::CODE_MID;
      end else begin
        trial <= next_trial;
      end
    end

    assign sar.trial[i] = trial;
  end
endmodule
`default_nettype wire

// ### rtl/arcs_top.sv
// converter set-up: range, coding and pair select around a dual sar
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module arcs_top (
  input wire logic sys_clk,  // register side clock, 10 MHz
  input wire logic rst_b,  // asynchronous, active low
  input wire logic ce,  // freezes register side state while low
  // link pins driven by the host
  input wire logic sclk,  // serial and conversion clock
  input wire logic cs_b,  // conversion frame select, active low
  input wire logic span_select,  // range / coding level
  input wire logic pair_select,  // channel pair level
  // analog front end
  input wire logic [1:0] comp,  // comparator outputs per converter
  output logic [11:0] dac_a,  // trial code to converter a dac
  output logic [11:0] dac_b,  // trial code to converter b dac
  output logic track_hold,  // high while the input is held
  output logic mux_chan,  // channel pair for both multiplexers
  output logic span_double,  // double-reference span selected
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic conv_done  // one-cycle pulse per accepted result
);
  arcs_sar_if sar ();

  // ---------------- frame-select domain ----------------
  logic span_a;  // span level at the frame falling edge
  logic pair_lat;  // pair level at the frame falling edge
  logic next_span_a;
  logic next_pair_lat;

  // both levels are taken exactly as they stand when the frame opens
  always_comb begin
    next_span_a = span_select;
    next_pair_lat = pair_select;
  end

  // the frame edge itself is the capture clock: no sclk edge exists yet
  always_ff @(negedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      span_a <= 1'b0;
      pair_lat <= 1'b0;
    end else begin
      span_a <= next_span_a;
      pair_lat <= next_pair_lat;
    end
  end

  // ---------------- serial clock domain ----------------
  logic [4:0] edge_cnt;  // falling edges seen this frame
  logic [4:0] next_edge_cnt;
  logic span_b;  // span level at the eighth falling edge
  logic next_span_b;

  // count edges and take the second span sample
  always_comb begin
    next_edge_cnt = edge_cnt;
    next_span_b = span_b;
    if (edge_cnt != arcs_pkg::EDGE_END) begin
      next_edge_cnt = edge_cnt + 5'h01;
    end
    if (edge_cnt == arcs_pkg::EDGE_SPAN_B) begin
      next_span_b = span_select;
    end
  end

  // the frame's own select ends the count, so a stopped sclk is harmless
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      edge_cnt <= 5'h00;
      span_b <= 1'b0;
    end else begin
      edge_cnt <= next_edge_cnt;
      span_b <= next_span_b;
    end
  end

  assign sar.edge_cnt = edge_cnt;
  assign sar.comp = comp;

  arcs_sar u_sar (
    .sclk(sclk),
    .cs_b(cs_b),
    .sar(sar)
  );

  // result hold registers survive the frame end for the crossing
  logic [11:0] hold_a;
  logic [11:0] hold_b;
  logic [11:0] next_hold_a;
  logic [11:0] next_hold_b;
  logic [2:0] hold_cfg;  // range, coding, pair of this result
  logic [2:0] next_hold_cfg;
  logic done_tgl;  // flips once per finished conversion
  logic next_done_tgl;
  logic coding_twos;  // coding in force for this frame

  // coding follows the second sample alone: its level sets it directly
  assign coding_twos = span_b;

  // last edge: code the binary result and hand it over
  // a frame cut short never reaches the done count, so nothing moves
  always_comb begin
    next_hold_a = hold_a;
    next_hold_b = hold_b;
    next_hold_cfg = hold_cfg;
    next_done_tgl = done_tgl;
    if (!cs_b && edge_cnt == arcs_pkg::EDGE_DONE) begin
      // twos complement is offset binary with the msb flipped
      if (coding_twos) begin
        next_hold_a = sar.trial[0] ^ arcs_pkg::CODE_MID;
        next_hold_b = sar.trial[1] ^ arcs_pkg::CODE_MID;
      end else begin
        next_hold_a = sar.trial[0];
        next_hold_b = sar.trial[1];
      end
      next_hold_cfg = {pair_lat, coding_twos, span_a};
      next_done_tgl = ~done_tgl;
    end
  end

  // sclk side hand-over registers
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_a <= 12'h000;
      hold_b <= 12'h000;
      hold_cfg <= 3'h0;
      done_tgl <= 1'b0;
    end else begin
      hold_a <= next_hold_a;
      hold_b <= next_hold_b;
      hold_cfg <= next_hold_cfg;
      done_tgl <= next_done_tgl;
    end
  end

  // front end controls: range and pair hold for the whole frame
  assign dac_a = sar.trial[0];
  assign dac_b = sar.trial[1];
  assign track_hold = !cs_b && (edge_cnt != arcs_pkg::EDGE_END);
  assign mux_chan = pair_lat;
  assign span_double = span_a;

  // ---------------- register clock domain ----------------
  logic tgl_s1;  // first synchroniser stage, read only by tgl_s2
  logic tgl_s2;
  logic tgl_s3;  // previous synchronised value for edge detect
  logic busy_s1;
  logic busy_s2;
  logic next_tgl_s1;
  logic next_tgl_s2;
  logic next_tgl_s3;
  logic next_busy_s1;
  logic next_busy_s2;
  logic arrive;  // a new result is stable in the hold registers

  // each stage takes only its predecessor; first stages feed nothing else
  always_comb begin
    next_tgl_s1 = done_tgl;
    next_tgl_s2 = tgl_s1;
    next_tgl_s3 = tgl_s2;
    next_busy_s1 = ~cs_b;
    next_busy_s2 = busy_s1;
  end

  // two-stage synchronisers for the done toggle and frame level
  // limitation: ce freezes only this side, the link keeps its own clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else if (ce) begin
      tgl_s1 <= next_tgl_s1;
      tgl_s2 <= next_tgl_s2;
      tgl_s3 <= next_tgl_s3;
      busy_s1 <= next_busy_s1;
      busy_s2 <= next_busy_s2;
    end
  end

  assign arrive = ce && (tgl_s2 != tgl_s3);

  logic [15:0] ctrl;  // software control word
  logic [11:0] res_a;
  logic [11:0] res_b;
  logic [2:0] res_cfg;
  logic new_flag;  // sticky: result not yet read
  logic [15:0] conv_cnt;  // results accepted, wraps
  logic [15:0] rd_q;
  logic done_q;
  logic [15:0] next_ctrl;
  logic [11:0] next_res_a;
  logic [11:0] next_res_b;
  logic [2:0] next_res_cfg;
  logic next_new_flag;
  logic [15:0] next_conv_cnt;
  logic [15:0] next_rd_q;
  logic next_done_q;
  logic accept;  // arrival that software lets through

  assign accept = arrive && ctrl[arcs_pkg::CTRL_ACCEPT];

  // register file, result capture and the read answer
  always_comb begin
    next_ctrl = ctrl;
    next_res_a = res_a;
    next_res_b = res_b;
    next_res_cfg = res_cfg;
    next_new_flag = new_flag;
    next_conv_cnt = conv_cnt;
    next_rd_q = 16'h0000;
    next_done_q = accept;
    if (wr_en && addr == arcs_pkg::REG_CTRL) begin
      next_ctrl = wr_data;
    end
    // reading result a clears the flag; an arrival in that cycle wins
    if (rd_en && addr == arcs_pkg::REG_RESULT_A) begin
      next_new_flag = 1'b0;
    end
    if (accept) begin
      next_res_a = hold_a;
      next_res_b = hold_b;
      next_res_cfg = hold_cfg;
      next_new_flag = 1'b1;
      next_conv_cnt = conv_cnt + 16'h0001;
    end
    if (rd_en) begin
      case (addr)
        arcs_pkg::REG_CTRL: begin
          next_rd_q = ctrl;
        end
        arcs_pkg::REG_STATUS: begin
          next_rd_q = 16'h0000;
          next_rd_q[arcs_pkg::ST_RANGE] = res_cfg[0];
          next_rd_q[arcs_pkg::ST_CODING] = res_cfg[1];
          next_rd_q[arcs_pkg::ST_PAIR] = res_cfg[2];
          next_rd_q[arcs_pkg::ST_NEW] = new_flag;
          next_rd_q[arcs_pkg::ST_BUSY] = busy_s2;
        end
        arcs_pkg::REG_RESULT_A: begin
          next_rd_q = {4'h0, res_a};
        end
        arcs_pkg::REG_RESULT_B: begin
          next_rd_q = {4'h0, res_b};
        end
        arcs_pkg::REG_COUNT: begin
          next_rd_q = conv_cnt;
        end
        default: begin
          next_rd_q = 16'h0000;  // unmapped reads as zero
        end
      endcase
    end
  end

  // register side state; clock enable low freezes it all
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= arcs_pkg::CTRL_RST;
      res_a <= 12'h000;
      res_b <= 12'h000;
      res_cfg <= 3'h0;
      new_flag <= 1'b0;
      conv_cnt <= 16'h0000;
      rd_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      res_a <= next_res_a;
      res_b <= next_res_b;
      res_cfg <= next_res_cfg;
      new_flag <= next_new_flag;
      conv_cnt <= next_conv_cnt;
      rd_q <= next_rd_q;
      done_q <= next_done_q;
    end
  end

  assign rd_data = rd_q;
  assign conv_done = done_q;
endmodule
`default_nettype wire

// ### dv/arcs_props.sv
// assertion checker for the converter set-up block
`timescale 1ns/1ns
`default_nettype none
module arcs_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic span_select,
  input wire logic pair_select,
  input wire logic [1:0] comp,
  input wire logic [11:0] dac_a,
  input wire logic [11:0] dac_b,
  input wire logic track_hold,
  input wire logic mux_chan,
  input wire logic span_double,
  input wire logic [3:0] addr,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic conv_done
);
  logic span_a;  // span level seen at frame start
  logic pair_a;  // pair level seen at frame start
  logic [4:0] n_edge;  // falling serial edges so far in the frame
  // own copy of the frame-start levels
  always_ff @(negedge cs_b) begin
    span_a <= span_select;
    pair_a <= pair_select;
  end
  // own edge count; saturates so long frames cannot wrap
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b)
      n_edge <= 5'h00;
    else if (n_edge != 5'h1F)
      n_edge <= n_edge + 5'h01;
  end
  property p_span;
    @(negedge sclk) disable iff (!rst_b || cs_b) span_double == span_a;
  endproperty
  a_span: assert property (p_span)
    else $error("span latch wrong");
  property p_pair;
    @(negedge sclk) disable iff (!rst_b || cs_b) mux_chan == pair_a;
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair latch wrong");
  property p_track;
    @(posedge sys_clk) disable iff (!rst_b)
      track_hold == (!cs_b && n_edge < 5'h10);
  endproperty
  a_track: assert property (p_track)
    else $error("hold window wrong");
  property p_idle;
    @(posedge sys_clk) disable iff (!rst_b)
      cs_b |-> dac_a == arcs_pkg::CODE_MID && dac_b == arcs_pkg::CODE_MID;
  endproperty
  a_idle: assert property (p_idle)
    else $error("trial not midscale");
  property p_msb_a;
    @(negedge sclk) disable iff (!rst_b || cs_b)
      n_edge == 5'h03 |=> dac_a[11] == $past(comp[0]);
  endproperty
  a_msb_a: assert property (p_msb_a)
    else $error("msb a wrong");
  property p_msb_b;
    @(negedge sclk) disable iff (!rst_b || cs_b)
      n_edge == 5'h03 |=> dac_b[11] == $past(comp[1]);
  endproperty
  a_msb_b: assert property (p_msb_b)
    else $error("msb b wrong");
  property p_pulse;
    @(posedge sys_clk) disable iff (!rst_b) conv_done |=> !conv_done;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("done pulse too long");
  property p_rdzero;
    @(posedge sys_clk) disable iff (!rst_b)
      !$past(rd_en) |-> rd_data == 16'h0000;
  endproperty
  a_rdzero: assert property (p_rdzero)
    else $error("read data not idle");
  c_done: cover property (@(posedge sys_clk) conv_done);
  c_mix: cover property (@(negedge sclk) n_edge == 5'h07 && span_select != span_a);
  c_stat: cover property (@(posedge sys_clk) rd_en && addr == 4'h1);
endmodule
bind arcs_top arcs_props u_props (.sys_clk, .rst_b, .sclk, .cs_b,
  .span_select, .pair_select, .comp, .dac_a, .dac_b, .track_hold,
  .mux_chan, .span_double, .addr, .rd_en, .rd_data, .conv_done);
`default_nettype wire

// ### dv/arcs_host.sv
// host serial master and comparator front end for the bench
`timescale 1ns/1ns
`default_nettype none
module arcs_host (
  input wire logic go,  // rising edge starts one frame
  input wire logic lvl_a,  // span level at frame start
  input wire logic lvl_b,  // span level at the eighth edge
  input wire logic pair,
  input wire logic [4:0] n_fall,  // falling edges given; 16 completes
  input wire logic [11:0] vin_a,  // inputs in lsb units
  input wire logic [11:0] vin_b,
  input wire logic [11:0] dac_a,
  input wire logic [11:0] dac_b,
  output logic sclk,
  output logic cs_b,
  output logic span_select,
  output logic pair_select,
  output logic [1:0] comp,
  output logic busy
);
  // input sits half an lsb up, so equal trial keeps the bit
  assign comp = {vin_b >= dac_b, vin_a >= dac_a};
  // serial clock stands high between frames
  initial begin
    sclk = 1'b1;
    span_select = 1'b0;
    pair_select = 1'b0;
    busy = 1'b0;
    // rise after time zero so every frame-select clear is surely seen
    #1 cs_b = 1'b1;
  end
  // one frame per request, levels steady around each sample point
  always @(posedge go) begin
    busy = 1'b1;
    span_select = lvl_a;
    pair_select = pair;
    #31 cs_b = 1'b0;
    for (int i = 1; i <= n_fall; i++) begin
      #24 sclk = 1'b0;
      if (i == 2)
        span_select = lvl_b;
      #24 sclk = 1'b1;
    end
    #24 cs_b = 1'b1;
    span_select = ~lvl_b;  // no longer sampled; change shows misuse
    pair_select = ~pair;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// ### dv/arcs_top_bench.sv
// self-checking bench for the converter set-up block
`timescale 1ns/1ns
`default_nettype none
module arcs_top_bench;
  logic sys_clk, rst_b, ce, go, lvl_a, lvl_b, pair, busy;
  logic sclk, cs_b, span_select, pair_select, track_hold, mux_chan;
  logic span_double, wr_en, rd_en, conv_done;
  logic [1:0] comp;
  logic [3:0] addr;
  logic [4:0] n_fall;
  logic [11:0] vin_a, vin_b, dac_a, dac_b;
  logic [15:0] wr_data, rd_data;
  logic [15:0] st = 16'h0000;  // model status word
  logic [11:0] res_q[$] = '{12'h000, 12'h000};  // model results a, b
  int n_fail = 0;
  int samples_checked = 0;
  int model_cnt = 0;  // results the model counts as accepted
  int pulses;
  arcs_top dut (.sys_clk, .rst_b, .ce, .sclk, .cs_b, .span_select,
    .pair_select, .comp, .dac_a, .dac_b, .track_hold, .mux_chan,
    .span_double, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .conv_done);
  arcs_host host (.go, .lvl_a, .lvl_b, .pair, .n_fall, .vin_a, .vin_b,
    .dac_a, .dac_b, .sclk, .cs_b, .span_select, .pair_select, .comp,
    .busy);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  // answer is looked at in the one cycle it stands
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  // one frame, then the model's view of every result register
  task automatic frame(input logic a, input logic b, input logic p,
    input logic [4:0] n, input logic acc, input logic [11:0] va,
    input logic [11:0] vb);
    logic ok;
    ok = (n == 5'h10) && acc;  // short frames give nothing
    @(posedge sys_clk);
    lvl_a <= a;
    lvl_b <= b;
    pair <= p;
    n_fall <= n;
    vin_a <= va;
    vin_b <= vb;
    go <= 1'b1;
    pulses = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      go <= 1'b0;
      #1 if (conv_done === 1'b1) pulses++;
    end
    if (ok) begin
      model_cnt++;
      st = {12'h000, 1'b1, p, b, a};
      res_q = '{va ^ {b, 11'h000}, vb ^ {b, 11'h000}};
    end
    chk(16'(pulses), {15'h0000, ok});
    chk({15'h0000, busy}, 16'h0000);
    rd(4'h1, st);
    rd(4'h2, {4'h0, res_q[0]});
    st[3] = 1'b0;
    rd(4'h3, {4'h0, res_q[1]});
    rd(4'h1, st);
    rd(4'h4, 16'(model_cnt));
  endtask
  initial begin
    void'($urandom(32'hA682));
    rst_b = 1'b1;
    ce = 1'b1;
    {go, lvl_a, lvl_b, pair, wr_en, rd_en} = 6'h00;
    addr = 4'h0;
    wr_data = 16'h0000;
    n_fall = 5'h10;
    vin_a = 12'h000;
    vin_b = 12'h000;
    // reset falls just after time zero so every async branch sees it
    #1 rst_b = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(4'h0, 16'h0001);
    rd(4'hF, 16'h0000);
    // a write while the clock enable is low must leave control alone
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(4'h0, 16'h0000);
    ce <= 1'b1;
    rd(4'h0, 16'h0001);
    // every level pair at both sample points, both channel pairs
    for (int k = 0; k < 8; k++)
      frame(k[0], k[1], k[2], 5'h10, 1'b1, 12'($urandom), 12'($urandom));
    frame(1'b1, 1'b1, 1'b0, 5'h10, 1'b1, 12'h800, 12'hFFF);
    wr(4'h3, 16'hFFFF);
    frame(1'b0, 1'b1, 1'b1, 5'h0A, 1'b1, 12'h123, 12'h456);
    wr(4'h0, 16'h0000);
    frame(1'b1, 1'b0, 1'b1, 5'h10, 1'b0, 12'h321, 12'h654);
    wr(4'h0, 16'h0001);
    frame(1'b0, 1'b0, 1'b1, 5'h10, 1'b1, 12'hFFF, 12'h001);
    close_out();
  end
endmodule
`default_nettype wire
